// File: src/rtfs_status_bank.sv
// Restore time and flash write status register bank with APB slave and interrupt.
// Function
// - Word one holds last two year digits and the month, both BCD.
// - BCD day of month in upper byte, BCD hour in lower byte of word two.
// - BCD minute in upper byte, BCD second in lower byte of word three.
// - Year's first two BCD digits and weekday code 0 to 6 in word four.
// - Program memory write progress kept as whole percentage from 0 to 100.
// - A write or transfer command zeroes the matching progress register first.
// - Standard ROM write progress kept as percentage 0 to 100, separate register.
// - Program memory wear index is unsigned 32-bit over two 16-bit registers.
// - Wear index above one hundred thousand raises flash error, code 1610.
// - Wear index keeps counting past the threshold, no saturation.
// - Wear index advances once per about two program memory writes.
//
// Our own choices: the register addresses and the APB register port.
`timescale 1ns/100ps
`include "rtfs_defs.svh"

module rtfs_status_bank (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic [11:0]            paddr,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [31:0]            pwdata,
  input  wire logic [3:0]             pstrb,
  output logic [31:0]                 prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic                   restore_load,
  input  wire rtfs_pkg::rtfs_stamp_t  restore_stamp,
  input  wire logic                   pm_cmd,
  input  wire rtfs_pkg::rtfs_progress_t pm_update,
  input  wire logic                   rom_cmd,
  input  wire rtfs_pkg::rtfs_progress_t rom_update,
  input  wire logic                   pm_write_op,
  output logic                        irq,
  output logic                        flash_error,
  output logic [15:0]                 flash_error_code
);

  // ==========================================================================
  // Helper functions

  // The engine should never report above 100, but a clip keeps software
  // from ever seeing an impossible percentage.
  function automatic logic [7:0] pct_clip(input logic [7:0] pct);
    if (pct > `RTFS_PCT_MAX) begin
      pct_clip = `RTFS_PCT_MAX;
    end else begin
      pct_clip = pct;
    end
  endfunction

  function automatic logic [31:0] word16(input logic [7:0] hi, input logic [7:0] lo);
    word16 = {16'h0000, hi, lo};
  endfunction

  // ==========================================================================
  // Declarations
  rtfs_pkg::rtfs_stamp_t     stamp_reg;
  rtfs_pkg::rtfs_stamp_t     stamp_next;
  logic [7:0]                pm_pct_reg;
  logic [7:0]                pm_pct_next;
  logic [7:0]                rom_pct_reg;
  logic [7:0]                rom_pct_next;
  logic [`RTFS_INT_WIDTH-1:0] int_status_reg;
  logic [`RTFS_INT_WIDTH-1:0] int_status_next;
  logic [`RTFS_INT_WIDTH-1:0] int_mask_reg;
  logic [`RTFS_INT_WIDTH-1:0] int_mask_next;
  logic [`RTFS_INT_WIDTH-1:0] int_set;
  logic [`RTFS_INT_WIDTH-1:0] int_clear;
  logic                      irq_reg;
  logic [15:0]               err_code_reg;
  logic                      err_flag_reg;
  rtfs_pkg::rtfs_apb_state_t state_reg;
  rtfs_pkg::rtfs_apb_state_t state_next;
  logic [31:0]               prdata_reg;
  logic [31:0]               prdata_next;
  logic                      pready_reg;
  logic                      pslverr_reg;
  logic                      pslverr_next;
  logic [31:0]               wear_index;
  logic                      wear_over;
  logic                      wear_cross;
  logic                      access;
  logic                      commit;
  logic                      answer;
  logic                      pready_next;
  logic                      pslverr_gated;
  logic [31:0]               prdata_gated;
  logic                      wr_commit;
  logic                      hit_year_month;
  logic                      hit_day_hour;
  logic                      hit_min_sec;
  logic                      hit_cent_wday;
  logic                      hit_pm_pct;
  logic                      hit_wear_low;
  logic                      hit_wear_high;
  logic                      hit_rom_pct;
  logic                      hit_int_status;
  logic                      hit_int_mask;
  logic                      hit_flash_err;
  logic                      hit_read_only;
  logic                      hit_any;
  logic [`RTFS_INT_WIDTH-1:0] wdata_bits;
  logic                      low_lane;
  logic                      pm_done;
  logic                      rom_done;

  // ==========================================================================
  // Wear index counter
  rtfs_wear_counter i_rtfs_wear_counter (
    .pclk        (pclk),
    .presetn     (presetn),
    .write_op    (pm_write_op),
    .index       (wear_index),
    .over_limit  (wear_over),
    .cross_pulse (wear_cross)
  );

  // ==========================================================================
  // Address decode
  assign hit_year_month = paddr == `RTFS_OFS_YEAR_MONTH;
  assign hit_day_hour   = paddr == `RTFS_OFS_DAY_HOUR;
  assign hit_min_sec    = paddr == `RTFS_OFS_MINUTE_SECOND;
  assign hit_cent_wday  = paddr == `RTFS_OFS_CENTURY_WEEKDAY;
  assign hit_pm_pct     = paddr == `RTFS_OFS_PM_PROGRESS;
  assign hit_wear_low   = paddr == `RTFS_OFS_WEAR_LOW;
  assign hit_wear_high  = paddr == `RTFS_OFS_WEAR_HIGH;
  assign hit_rom_pct    = paddr == `RTFS_OFS_ROM_PROGRESS;
  assign hit_int_status = paddr == `RTFS_OFS_INT_STATUS;
  assign hit_int_mask   = paddr == `RTFS_OFS_INT_MASK;
  assign hit_flash_err  = paddr == `RTFS_OFS_FLASH_ERROR;

  assign hit_read_only  = hit_year_month | hit_day_hour | hit_min_sec | hit_cent_wday |
                          hit_pm_pct | hit_wear_low | hit_wear_high | hit_rom_pct |
                          hit_flash_err;
  assign hit_any        = hit_read_only | hit_int_status | hit_int_mask;

  // One wait state is inserted so that read data and pready both come from
  // flip-flops; the cost is one extra cycle per access.
  assign access    = psel && penable;
  assign commit    = access && pready_reg;
  // An answer starts only from IDLE, so the cycle in which pready stands
  // can never start a second answer for the same access.
  assign answer        = access && (state_reg == rtfs_pkg::RTFS_IDLE);
  assign pready_next   = answer;
  assign pslverr_gated = answer ? pslverr_next : 1'b0;
  assign prdata_gated  = answer ? prdata_next : `RTFS_RST_WORD;
  assign wr_commit = commit && pwrite && !pslverr_reg;
  assign low_lane  = pstrb[0];
  assign wdata_bits = pwdata[`RTFS_INT_WIDTH-1:0];

  // ==========================================================================
  // APB phase sequencing
  // WAIT is the single cycle in which pready stands.
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      rtfs_pkg::RTFS_IDLE: begin
        if (answer) begin
          state_next = rtfs_pkg::RTFS_WAIT;
        end
      end
      rtfs_pkg::RTFS_WAIT: begin
        state_next = rtfs_pkg::RTFS_IDLE;
      end
      rtfs_pkg::RTFS_DONE: begin
        state_next = rtfs_pkg::RTFS_IDLE;
      end
      default: begin
        state_next = rtfs_pkg::RTFS_IDLE;
      end
    endcase
  end

  // ==========================================================================
  // Read data selection
  // reads have no side effect
  always_comb begin
    prdata_next  = `RTFS_RST_WORD;
    pslverr_next = 1'b0;
    if (!hit_any) begin
      pslverr_next = 1'b1;
    end else if (pwrite && hit_read_only) begin
      pslverr_next = 1'b1;
    end else if (pwrite) begin
      prdata_next = `RTFS_RST_WORD;
    end else if (hit_year_month) begin
      prdata_next = word16(stamp_reg.year_low, stamp_reg.month);
    end else if (hit_day_hour) begin
      prdata_next = word16(stamp_reg.day, stamp_reg.hour);
    end else if (hit_min_sec) begin
      prdata_next = word16(stamp_reg.minute, stamp_reg.second);
    end else if (hit_cent_wday) begin
      prdata_next = word16(stamp_reg.century, stamp_reg.weekday);
    end else if (hit_pm_pct) begin
      prdata_next = {24'h00_0000, pm_pct_reg};
    end else if (hit_wear_low) begin
      // The halves are not latched together, so a count between two reads
      // can tear the value; software should read high, low, high again.
      // low half of index
      prdata_next = {16'h0000, wear_index[15:0]};
    end else if (hit_wear_high) begin
      prdata_next = {16'h0000, wear_index[31:16]};
    end else if (hit_rom_pct) begin
      prdata_next = {24'h00_0000, rom_pct_reg};
    end else if (hit_int_status) begin
      prdata_next = {28'h000_0000, int_status_reg};
    end else if (hit_int_mask) begin
      prdata_next = {28'h000_0000, int_mask_reg};
    end else begin
      prdata_next = {15'h0000, err_flag_reg, err_code_reg};
    end
  end

  // ==========================================================================
  // APB slave registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg   <= rtfs_pkg::RTFS_IDLE;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= `RTFS_RST_WORD;
    end else begin
      state_reg   <= state_next;
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_gated;
      prdata_reg  <= prdata_gated;
    end
  end

  // ==========================================================================
  // Restore timestamp capture
  // stamp captured on restore
  // weekday kept to code 0 to 6
  // An out of range weekday is stored as Sunday so software never sees a bad code.
  always_comb begin
    stamp_next = stamp_reg;
    if (restore_load) begin
      stamp_next = restore_stamp;
      if (restore_stamp.weekday > 8'h06) begin
        stamp_next.weekday = 8'h00;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stamp_reg <= `RTFS_RST_STAMP;
    end else begin
      stamp_reg <= stamp_next;
    end
  end

  // ==========================================================================
  // Write progress
  // command zeroes progress first
  assign pm_pct_next  = pm_cmd ? `RTFS_RST_PCT :
                        pm_update.valid ? pct_clip(pm_update.pct) : pm_pct_reg;
  assign rom_pct_next = rom_cmd ? `RTFS_RST_PCT :
                        rom_update.valid ? pct_clip(rom_update.pct) : rom_pct_reg;

  assign pm_done  = !pm_cmd && pm_update.valid && (pct_clip(pm_update.pct) == `RTFS_PCT_MAX) &&
                    (pm_pct_reg != `RTFS_PCT_MAX);
  assign rom_done = !rom_cmd && rom_update.valid && (pct_clip(rom_update.pct) == `RTFS_PCT_MAX) &&
                    (rom_pct_reg != `RTFS_PCT_MAX);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pm_pct_reg  <= `RTFS_RST_PCT;
      rom_pct_reg <= `RTFS_RST_PCT;
    end else begin
      pm_pct_reg  <= pm_pct_next;
      rom_pct_reg <= rom_pct_next;
    end
  end

  // ==========================================================================
  // Flash error reporting
  // error flag and code
  // The flag follows the compare level, so it stays up while the index is
  // above the limit, which is until reset or until the 32-bit index wraps to zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_flag_reg <= 1'b0;
      err_code_reg <= `RTFS_NO_ERROR_CODE;
    end else begin
      err_flag_reg <= wear_over;
      err_code_reg <= wear_over ? `RTFS_ERROR_CODE : `RTFS_NO_ERROR_CODE;
    end
  end

  // ==========================================================================
  // Interrupt status and mask
  assign int_set[`RTFS_INT_RESTORE]   = restore_load;
  assign int_set[`RTFS_INT_PM_DONE]   = pm_done;
  assign int_set[`RTFS_INT_ROM_DONE]  = rom_done;
  assign int_set[`RTFS_INT_FLASH_ERR] = wear_cross;

  assign int_clear = (wr_commit && hit_int_status && low_lane) ? wdata_bits : `RTFS_RST_INT;

  // A new event in the same cycle as its clear stays set, so none is lost.
  assign int_status_next = (int_status_reg & ~int_clear) | int_set;
  assign int_mask_next   = (wr_commit && hit_int_mask && low_lane) ? wdata_bits : int_mask_reg;

  // The interrupt is taken from the next state values so that it rises in the
  // same cycle as the status bit and still leaves straight from a flip-flop.

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_status_reg <= `RTFS_RST_INT;
      int_mask_reg   <= `RTFS_RST_INT;
      irq_reg        <= 1'b0;
    end else begin
      int_status_reg <= int_status_next;
      int_mask_reg   <= int_mask_next;
      irq_reg        <= |(int_status_next & int_mask_next);
    end
  end

  // ==========================================================================
  // Outputs
  assign prdata           = prdata_reg;
  assign pready           = pready_reg;
  assign pslverr          = pslverr_reg;
  assign irq              = irq_reg;
  assign flash_error      = err_flag_reg;
  assign flash_error_code = err_code_reg;

endmodule

// File: src/rtfs_defs.svh
// Offsets, field positions, reset values and limits of the restore time and flash write status bank.
`ifndef RTFS_DEFS_SVH
`define RTFS_DEFS_SVH

// ==========================================================================
// Register byte offsets on the APB bus
`define RTFS_OFS_YEAR_MONTH      12'h000
`define RTFS_OFS_DAY_HOUR        12'h004
`define RTFS_OFS_MINUTE_SECOND   12'h008
`define RTFS_OFS_CENTURY_WEEKDAY 12'h00C
`define RTFS_OFS_PM_PROGRESS     12'h010
`define RTFS_OFS_WEAR_LOW        12'h014
`define RTFS_OFS_WEAR_HIGH       12'h018
`define RTFS_OFS_ROM_PROGRESS    12'h01C
`define RTFS_OFS_INT_STATUS      12'h020
`define RTFS_OFS_INT_MASK        12'h024
`define RTFS_OFS_FLASH_ERROR     12'h028

// ==========================================================================
// Field positions inside a 16-bit timestamp word
`define RTFS_HI_BYTE_MSB 15
`define RTFS_HI_BYTE_LSB 8
`define RTFS_LO_BYTE_MSB 7
`define RTFS_LO_BYTE_LSB 0

// ==========================================================================
// Interrupt status and mask bit positions
`define RTFS_INT_RESTORE   0
`define RTFS_INT_PM_DONE   1
`define RTFS_INT_ROM_DONE  2
`define RTFS_INT_FLASH_ERR 3
`define RTFS_INT_WIDTH     4

// ==========================================================================
// Reset values and limits
`define RTFS_RST_STAMP     64'h0000_0000_0000_0000
`define RTFS_RST_PCT       8'h00
`define RTFS_RST_WEAR      32'h0000_0000
`define RTFS_RST_INT       4'h0
`define RTFS_RST_WORD      32'h0000_0000
`define RTFS_PCT_MAX       8'h64
`define RTFS_WEAR_LIMIT    32'h0001_86A0
`define RTFS_ERROR_CODE    16'h064A
`define RTFS_NO_ERROR_CODE 16'h0000

`endif

// File: src/rtfs_pkg.sv
// Types shared by the restore time and flash write status bank.
package rtfs_pkg;

  // ==========================================================================
  // Restore timestamp, every field two BCD digits except the weekday code.
  typedef struct packed {
    logic [7:0] year_low;
    logic [7:0] month;
    logic [7:0] day;
    logic [7:0] hour;
    logic [7:0] minute;
    logic [7:0] second;
    logic [7:0] century;
    logic [7:0] weekday;
  } rtfs_stamp_t;

  // ==========================================================================
  // Progress report from the flash write engine.
  typedef struct packed {
    logic       valid;
    logic [7:0] pct;
  } rtfs_progress_t;

  // ==========================================================================
  // APB access phase tracking.
  typedef enum logic [1:0] {
    RTFS_IDLE = 2'b00,
    RTFS_WAIT = 2'b01,
    RTFS_DONE = 2'b10
  } rtfs_apb_state_t;

endpackage

// File: src/rtfs_wear_counter.sv
// Program memory wear index counter with threshold error detection.
`timescale 1ns/100ps
`include "rtfs_defs.svh"

module rtfs_wear_counter (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        write_op,
  output logic [31:0]      index,
  output logic             over_limit,
  output logic             cross_pulse
);

  logic        half_reg;
  logic        half_next;
  logic [31:0] index_reg;
  logic [31:0] index_next;
  logic        over_reg;
  logic        over_next;
  logic        cross_reg;

  // ==========================================================================
  // Counting
  // every second write
  assign half_next  = write_op ? ~half_reg : half_reg;
  assign index_next = (write_op && half_reg) ? index_reg + 32'h0000_0001 : index_reg;
  assign over_next  = index_next > `RTFS_WEAR_LIMIT;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_reg  <= 1'b0;
      index_reg <= `RTFS_RST_WEAR;
      over_reg  <= 1'b0;
      cross_reg <= 1'b0;
    end else begin
      half_reg  <= half_next;
      index_reg <= index_next;
      over_reg  <= over_next;
      cross_reg <= over_next && !over_reg;
    end
  end

  assign index       = index_reg;
  assign over_limit  = over_reg;
  assign cross_pulse = cross_reg;

endmodule

// File: bench/rtfs_status_bank_monitor.sv
// Concurrent checks on the ports of the restore time and flash write status bank.
`timescale 1ns/100ps

module rtfs_status_bank_monitor (
  input wire logic                    pclk,
  input wire logic                    presetn,
  input wire logic [11:0]             paddr,
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pwrite,
  input wire logic [31:0]             pwdata,
  input wire logic [3:0]              pstrb,
  input wire logic [31:0]             prdata,
  input wire logic                    pready,
  input wire logic                    pslverr,
  input wire logic                    restore_load,
  input wire rtfs_pkg::rtfs_stamp_t   restore_stamp,
  input wire logic                    pm_cmd,
  input wire rtfs_pkg::rtfs_progress_t pm_update,
  input wire logic                    rom_cmd,
  input wire rtfs_pkg::rtfs_progress_t rom_update,
  input wire logic                    pm_write_op,
  input wire logic                    irq,
  input wire logic                    flash_error,
  input wire logic [15:0]             flash_error_code
);
  // ==========================================================================
  // Bus decode
  wire rd_done = pready && !pwrite;
  wire ro_addr = (paddr <= 12'h01C) || (paddr == 12'h028);

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ==========================================================================
  // Assertions
  AST_ONE_WAIT: assert property (psel && penable && !pready |=> pready)
    else $error("access phase not answered after one wait state");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("pready stood longer than one cycle");
  AST_RO_WRITE: assert property (pready && pwrite && ro_addr |-> pslverr)
    else $error("write to a read-only register accepted");
  AST_UNMAPPED: assert property (pready && paddr > 12'h028 |-> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");
  AST_IDLE_DATA: assert property (!rd_done |-> prdata == 32'h0000_0000)
    else $error("read data outside a read answer");
  AST_UPPER_ZERO: assert property (rd_done && paddr != 12'h028 |-> prdata[31:16] == 16'h0000)
    else $error("bits above a 16-bit register not zero");
  AST_ERR_WORD: assert property (rd_done && paddr == 12'h028 |-> prdata[16] == flash_error
                                && prdata[15:0] == flash_error_code)
    else $error("error word differs from error outputs");
  AST_ERR_CODE: assert property (flash_error |-> flash_error_code == 16'h064A)
    else $error("error code wrong while flash error raised");
  AST_NO_CODE: assert property (!flash_error |-> flash_error_code == 16'h0000)
    else $error("error code present without flash error");
  AST_ERR_HOLDS: assert property (flash_error |=> flash_error)
    else $error("flash error dropped while counting on");
  AST_ERR_CAUSE: assert property ($rose(flash_error) |-> $past(pm_write_op, 2))
    else $error("flash error rose without a write operation");

  COV_READ: cover property (rd_done && !pslverr);
  COV_REFUSED: cover property (pready && pslverr);
  COV_IRQ: cover property ($rose(irq));
endmodule

bind rtfs_status_bank rtfs_status_bank_monitor i_rtfs_status_bank_monitor (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .restore_load(restore_load), .restore_stamp(restore_stamp), .pm_cmd(pm_cmd), .pm_update(pm_update),
  .rom_cmd(rom_cmd), .rom_update(rom_update), .pm_write_op(pm_write_op), .irq(irq),
  .flash_error(flash_error), .flash_error_code(flash_error_code)
);

// File: bench/rtfs_status_bank_test.sv
// Directed APB testbench for the restore time and flash write status bank.
`timescale 1ns/100ps

module rtfs_status_bank_test;
  logic                     pclk = 1'b0;
  logic                     presetn = 1'b0;
  logic [11:0]              paddr = 12'h000;
  logic                     psel = 1'b0;
  logic                     penable = 1'b0;
  logic                     pwrite = 1'b0;
  logic [31:0]              pwdata = 32'h0000_0000;
  logic [3:0]               pstrb = 4'hF;
  logic [31:0]              prdata;
  logic                     pready;
  logic                     pslverr;
  logic                     restore_load = 1'b0;
  rtfs_pkg::rtfs_stamp_t    restore_stamp = '0;
  logic                     pm_cmd = 1'b0;
  rtfs_pkg::rtfs_progress_t pm_update = '0;
  logic                     rom_cmd = 1'b0;
  rtfs_pkg::rtfs_progress_t rom_update = '0;
  logic                     pm_write_op = 1'b0;
  logic                     irq;
  logic                     flash_error;
  logic [15:0]              flash_error_code;
  int                       num_errors = 0;
  int                       n_tests = 0;

  rtfs_status_bank i_rtfs_status_bank (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .restore_load(restore_load), .restore_stamp(restore_stamp), .pm_cmd(pm_cmd), .pm_update(pm_update),
    .rom_cmd(rom_cmd), .rom_update(rom_update), .pm_write_op(pm_write_op), .irq(irq),
    .flash_error(flash_error), .flash_error_code(flash_error_code)
  );

  always #10 pclk = ~pclk;

  // ==========================================================================
  // Shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // The master waits for pready with no assumed latency; only the count cuts a hang.
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d, input logic [31:0] exp,
                     input logic experr);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge pclk);
    end
    if (pready !== 1'b1) begin
      num_errors++;
      $display("unexpected at %0t: no pready at address %h", $time, a);
    end
    if (!w) check(prdata, exp);
    check({31'h0, pslverr}, {31'h0, experr});
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic prog(input logic rom, input logic cmd, input logic v, input logic [7:0] p);
    @(posedge pclk);
    pm_cmd <= cmd & !rom;
    rom_cmd <= cmd & rom;
    pm_update <= {v & !rom, p};
    rom_update <= {v & rom, p};
    @(posedge pclk);
    pm_cmd <= 1'b0;
    rom_cmd <= 1'b0;
    pm_update <= '0;
    rom_update <= '0;
  endtask

  task automatic load(input logic [63:0] s);
    @(posedge pclk);
    restore_stamp <= s;
    restore_load <= 1'b1;
    @(posedge pclk);
    restore_load <= 1'b0;
  endtask

  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // Tests
  initial begin
    logic [11:0] pa;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 11; i++) apb(12'(i * 4), 1'b0, 32'h0, 32'h0, 1'b0);
    apb(12'h030, 1'b0, 32'h0, 32'h0, 1'b1);
    $display("test done: reset values");
    load({8'h93, 8'h07, 8'h31, 8'h10, 8'h35, 8'h48, 8'h19, 8'h06});
    apb(12'h000, 1'b0, 32'h0, 32'h0000_9307, 1'b0);
    apb(12'h000, 1'b0, 32'h0, 32'h0000_9307, 1'b0);
    apb(12'h004, 1'b0, 32'h0, 32'h0000_3110, 1'b0);
    apb(12'h008, 1'b0, 32'h0, 32'h0000_3548, 1'b0);
    apb(12'h00C, 1'b0, 32'h0, 32'h0000_1906, 1'b0);
    apb(12'h000, 1'b1, 32'h0000_1234, 32'h0, 1'b1);
    apb(12'h000, 1'b0, 32'h0, 32'h0000_9307, 1'b0);
    load({8'h24, 8'h12, 8'h01, 8'h23, 8'h59, 8'h00, 8'h20, 8'h07});
    apb(12'h00C, 1'b0, 32'h0, 32'h0000_2000, 1'b0);
    $display("test done: restore stamp");
    for (int r = 0; r < 2; r++) begin
      pa = r ? 12'h01C : 12'h010;
      prog(r[0], 1'b0, 1'b1, 8'd50);
      apb(pa, 1'b0, 32'h0, 32'd50, 1'b0);
      prog(r[0], 1'b0, 1'b1, 8'd200);
      apb(pa, 1'b0, 32'h0, 32'd100, 1'b0);
      prog(r[0], 1'b1, 1'b0, 8'd0);
      apb(pa, 1'b0, 32'h0, 32'd0, 1'b0);
      prog(r[0], 1'b1, 1'b1, 8'd30);
      apb(pa, 1'b0, 32'h0, 32'd0, 1'b0);
    end
    $display("test done: progress");
    apb(12'h020, 1'b0, 32'h0, 32'h0000_0007, 1'b0);
    check({31'h0, irq}, 32'h0);
    apb(12'h024, 1'b1, 32'h0000_0001, 32'h0, 1'b0);
    repeat (3) @(posedge pclk);
    check({31'h0, irq}, 32'h1);
    apb(12'h024, 1'b0, 32'h0, 32'h0000_0001, 1'b0);
    apb(12'h020, 1'b1, 32'h0000_0001, 32'h0, 1'b0);
    apb(12'h020, 1'b0, 32'h0, 32'h0000_0006, 1'b0);
    pstrb <= 4'h0;
    apb(12'h024, 1'b1, 32'h0000_000F, 32'h0, 1'b0);
    pstrb <= 4'hF;
    apb(12'h024, 1'b0, 32'h0, 32'h0000_0001, 1'b0);
    repeat (3) @(posedge pclk);
    check({31'h0, irq}, 32'h0);
    apb(12'h024, 1'b1, 32'h0000_000F, 32'h0, 1'b0);
    repeat (3) @(posedge pclk);
    check({31'h0, irq}, 32'h1);
    apb(12'h020, 1'b1, 32'h0000_000F, 32'h0, 1'b0);
    apb(12'h020, 1'b0, 32'h0, 32'h0000_0000, 1'b0);
    check({31'h0, irq}, 32'h0);
    $display("test done: interrupt");
    for (int k = 1; k <= 7; k++) begin
      @(posedge pclk);
      pm_write_op <= 1'b1;
      @(posedge pclk);
      pm_write_op <= 1'b0;
      if (k == 5 || k == 6) apb(12'h014, 1'b0, 32'h0, 32'(k / 2), 1'b0);
    end
    apb(12'h014, 1'b0, 32'h0, 32'h0000_0003, 1'b0);
    apb(12'h018, 1'b0, 32'h0, 32'h0000_0000, 1'b0);
    apb(12'h028, 1'b0, 32'h0, 32'h0000_0000, 1'b0);
    check({15'h0000, flash_error, flash_error_code}, 32'h0000_0000);
    apb(12'h014, 1'b1, 32'h0000_FFFF, 32'h0, 1'b1);
    apb(12'h014, 1'b0, 32'h0, 32'h0000_0003, 1'b0);
    $display("test done: wear index");
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(12'h000, 1'b0, 32'h0, 32'h0000_0000, 1'b0);
    apb(12'h014, 1'b0, 32'h0, 32'h0000_0000, 1'b0);
    $display("test done: second reset");
    wrap_up();
  end

  initial begin
    repeat (5000) @(posedge pclk);
    num_errors++;
    $display("unexpected at %0t: watchdog expired", $time);
    wrap_up();
  end
endmodule
